// ---- nvm_port_defs.vh ----
`ifndef NVM_PORT_DEFS_VH
`define NVM_PORT_DEFS_VH

// =====================================================================
// action select codes (hi, lo)
`define ACT_ADDR        2'h0
`define ACT_DATA        2'h1
`define ACT_CMD         2'h2
`define ACT_IDLE        2'h3

// =====================================================================
// command codes
`define CMD_CHIP_ERASE  8'h80
`define CMD_WRITE_FLASH 8'h10
`define CMD_NOP         8'h00

// =====================================================================
// erased value and entry pattern
`define ERASED_BYTE     8'hFF
`define ENTRY_PATTERN   4'h0

// =====================================================================
// timing, figures as printed
`define CLK_PERIOD_NS   40
`define ENTRY_GUARD_NS  100
`define MIN_ENTRY_PULSES 6

// =====================================================================
// array geometry defaults
`define PAGE_WORD_BITS  6
`define FLASH_ADDR_BITS 13
`define EE_ADDR_BITS    9

`endif

// ---- sync2.v ----
`timescale 1ns/100ps
`include "nvm_port_defs.vh"

// =====================================================================
// two flop synchroniser for a bundle of pin levels
module sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // pins in, synchronised levels out
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_sync
);

    reg [WIDTH-1:0] meta_ff;

    // first stage feeds only the second stage
    always @(posedge clk) begin
        if (rst) begin
            meta_ff  <= {WIDTH{1'b0}};
            pin_sync <= {WIDTH{1'b0}};
        end else begin
            meta_ff  <= pin_in;
            pin_sync <= meta_ff;
        end
    end

endmodule // sync2

// ---- skid_buf2.v ----
`timescale 1ns/100ps

// =====================================================================
// two entry buffer, valid/ready on both sides
module skid_buf2 #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] slot0_ff;
    reg [WIDTH-1:0] slot1_ff;
    reg [1:0]       count_ff;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign out_data  = slot0_ff;

    // slot0 is the head; slot1 holds the word behind it
    always @(posedge clk) begin
        if (rst) begin
            count_ff <= 2'h0;
            slot0_ff <= {WIDTH{1'b0}};
            slot1_ff <= {WIDTH{1'b0}};
        end else begin
            if (pop) begin
                slot0_ff <= (count_ff == 2'h2) ? slot1_ff : in_data;
                if (push && count_ff == 2'h2)
                    slot1_ff <= in_data;
            end else if (push) begin
                if (count_ff == 2'h0)
                    slot0_ff <= in_data;
                else
                    slot1_ff <= in_data;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // skid_buf2

// ---- nvm_prog_port.v ----
// How it works
// RL1 - programmer pulses clock six times, reset low
// RL2 - select pins zero 100 ns before high voltage
// RL3 - select change within 100 ns blocks entry
// RL4 - programmer waits 50 us before first command
// RL5 - command and address held across operations
// RL6 - address high byte held until reloaded
// RL7 - erased locations read back as FF
// RL8 - erase clears flash, eeprom, locks; fuses kept
// RL9 - preserve fuse keeps eeprom on erase
// RL10 - action 10, byte 0 loads command
// RL11 - action 00 loads address low or high
// RL12 - action 01 loads data low or high
// RL13 - decode 80 erase, 10 write flash
// RL14 - write strobe starts erase, ready drops
// RL15 - page load copies data word to buffer
// RL16 - low bits word, upper bits page
// RL17 - write strobe programs page, ready low
// RL18 - programmer erases before reprogramming
// RL19 - programmer fills buffer then writes page
// RL20 - ready low while busy, high otherwise
// RL21 - data bus driven only while enable low
// RL22 - action 11 does nothing
// RL23 - pins sampled at strobe rise; busy ignores
`timescale 1ns/100ps
`include "nvm_port_defs.vh"

module nvm_prog_port #(
    parameter PAGE_BITS  = `PAGE_WORD_BITS,
    parameter ADDR_BITS  = `FLASH_ADDR_BITS,
    parameter EE_BITS    = `EE_ADDR_BITS,
    parameter ERASE_CYC  = 64,
    parameter PROG_CYC   = 16
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // mode entry
    input  wire       hv_reset,
    input  wire [3:0] entry_select,
    output reg        prog_mode_ff,
    // strobes
    input  wire       load_strobe_clock_pin,
    input  wire       page_load_strobe,
    input  wire       write_n,
    input  wire       output_enable_n,
    // selects
    input  wire       action_select_hi,
    input  wire       action_select_lo,
    input  wire       byte_select_primary,
    // data bus, three signal form
    input  wire [7:0] data_in,
    output reg  [7:0] data_out_ff,
    output wire       data_oe_n,
    // status and fuses
    input  wire       eeprom_preserve_fuse,
    output wire       ready_flag,
    output reg        lock_bits_set_ff
);

    localparam WORDS = 1 << ADDR_BITS;
    localparam PAGEW = 1 << PAGE_BITS;
    localparam EEW   = 1 << EE_BITS;
    // the wipe counter must reach the larger of the two arrays
    localparam WIPE_BITS = (ADDR_BITS > EE_BITS) ? ADDR_BITS : EE_BITS;
    localparam WIPE_END  = (WORDS > EEW) ? WORDS : EEW;
    localparam GUARD_CYC = (`ENTRY_GUARD_NS + `CLK_PERIOD_NS - 1)
                           / `CLK_PERIOD_NS;

    // state codes
    localparam ST_IDLE  = 2'h0;
    localparam ST_ERASE = 2'h1;
    localparam ST_PROG  = 2'h2;
    localparam ST_DRAIN = 2'h3;

    // =================================================================
    // pin synchronisation
    wire [20:0] pin_raw = {eeprom_preserve_fuse, hv_reset, entry_select,
                           load_strobe_clock_pin, page_load_strobe,
                           write_n, output_enable_n, action_select_hi,
                           action_select_lo, byte_select_primary, data_in};
    wire [20:0] pin_s;

    sync2 #(.WIDTH(21)) u_sync (
        .clk      (clk),
        .rst      (rst),
        .pin_in   (pin_raw),
        .pin_sync (pin_s)
    );

    wire       s_fuse = pin_s[20];
    wire       s_hv   = pin_s[19];
    wire [3:0] s_ent  = pin_s[18:15];
    wire       s_xclk = pin_s[14];
    wire       s_pl   = pin_s[13];
    wire       s_wr_n = pin_s[12];
    wire       s_oe_n = pin_s[11];
    wire [1:0] s_act  = pin_s[10:9];
    wire       s_bs   = pin_s[8];
    wire [7:0] s_data = pin_s[7:0];

    // =================================================================
    // edge detection on synchronised strobes
    reg        xclk_d_ff;
    reg        pl_d_ff;
    reg        wr_d_ff;
    reg        hv_d_ff;
    reg [2:0]  pulse_cnt_ff;
    reg [3:0]  ent_hold_ff;
    reg [7:0]  guard_ff;
    reg        entry_bad_ff;

    wire xclk_rise = s_xclk && !xclk_d_ff;
    wire pl_rise   = s_pl && !pl_d_ff;
    wire wr_fall   = !s_wr_n && wr_d_ff;
    wire hv_rise   = s_hv && !hv_d_ff;

    // mode entry: count clock pulses with reset low, then guard window
    always @(posedge clk) begin
        if (rst) begin
            xclk_d_ff    <= 1'b0;
            pl_d_ff      <= 1'b0;
            wr_d_ff      <= 1'b0;  // sync resets low: no false fall
            hv_d_ff      <= 1'b0;
            pulse_cnt_ff <= 3'h0;
            ent_hold_ff  <= 4'h0;
            guard_ff     <= 8'h00;
            entry_bad_ff <= 1'b0;
            prog_mode_ff <= 1'b0;
        end else begin
            xclk_d_ff <= s_xclk;
            pl_d_ff   <= s_pl;
            wr_d_ff   <= s_wr_n;
            hv_d_ff   <= s_hv;
            if (!s_hv) begin
                prog_mode_ff <= 1'b0;
                entry_bad_ff <= 1'b0;
                if (xclk_rise && pulse_cnt_ff != 3'h7)
                    pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
            end else if (hv_rise) begin
                ent_hold_ff  <= s_ent;
                guard_ff     <= GUARD_CYC[7:0];
                entry_bad_ff <= (s_ent != `ENTRY_PATTERN) ||
                                (pulse_cnt_ff < `MIN_ENTRY_PULSES);
            end else if (guard_ff != 8'h00) begin
                if (s_ent != ent_hold_ff)
                    entry_bad_ff <= 1'b1;                     // [RL3]
                guard_ff <= guard_ff - 8'h01;
                if (guard_ff == 8'h01 && !entry_bad_ff &&
                    s_ent == ent_hold_ff)
                    prog_mode_ff <= 1'b1;                     // [RL3]
            end
            if (!s_hv)
                guard_ff <= 8'h00;
            if (hv_rise)
                pulse_cnt_ff <= 3'h0;
        end
    end

    // =================================================================
    // command, address and data latches
    reg [7:0]  cmd_ff;
    reg [7:0]  addr_lo_ff;
    reg [7:0]  addr_hi_ff;
    reg [7:0]  dlo_ff;
    reg [7:0]  dhi_ff;
    reg [1:0]  state_ff;
    reg [1:0]  nxt_state;
    reg [15:0] busy_cnt_ff;
    reg [PAGE_BITS-1:0] drain_idx_ff;

    wire idle = (state_ff == ST_IDLE);
    wire live = prog_mode_ff && idle;            // [RL23]

    // clock and page load strobes act on their rising edge, write_n on its fall; only while idle in programming mode
    always @(posedge clk) begin
        if (rst) begin
            cmd_ff     <= `CMD_NOP;
            addr_lo_ff <= 8'h00;
            addr_hi_ff <= 8'h00;
            dlo_ff     <= 8'h00;
            dhi_ff     <= 8'h00;
        end else if (live && xclk_rise) begin
            case (s_act)
                `ACT_CMD: begin
                    if (!s_bs)
                        cmd_ff <= s_data;                      // [RL10]
                end
                `ACT_ADDR: begin
                    if (s_bs)
                        addr_hi_ff <= s_data;            // [RL11] [RL6]
                    else
                        addr_lo_ff <= s_data;                  // [RL11]
                end
                `ACT_DATA: begin
                    if (s_bs)
                        dhi_ff <= s_data;                      // [RL12]
                    else
                        dlo_ff <= s_data;                      // [RL12]
                end
                default: begin
                    cmd_ff <= cmd_ff;                          // [RL22]
                end
            endcase
        end
    end
    // latches above persist until reloaded                     [RL5]

    wire [15:0] word_addr = {addr_hi_ff, addr_lo_ff};
    wire is_erase = (cmd_ff == `CMD_CHIP_ERASE);               // [RL13]
    wire is_wflash = (cmd_ff == `CMD_WRITE_FLASH);             // [RL13]

    // =================================================================
    // page latch feeds a two entry buffer toward the buffer array
    wire        buf_in_ready;
    wire        buf_out_valid;
    wire [PAGE_BITS+15:0] buf_out;
    wire        buf_push = live && pl_rise && s_bs && is_wflash; // [RL15]

    skid_buf2 #(.WIDTH(PAGE_BITS + 16)) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (buf_push),
        .in_ready  (buf_in_ready),
        .in_data   ({word_addr[PAGE_BITS-1:0], dhi_ff, dlo_ff}),
        .out_valid (buf_out_valid),
        .out_ready (idle),
        .out_data  (buf_out)
    );

    // =================================================================
    // memories
    reg [15:0] page_buf [0:PAGEW-1];
    reg [15:0] flash_mem [0:WORDS-1];
    reg [7:0]  ee_mem [0:EEW-1];
    reg [WIPE_BITS:0] wipe_ff;

    // page buffer writes drain from the skid buffer
    always @(posedge clk) begin
        if (buf_out_valid && idle)
            page_buf[buf_out[PAGE_BITS+15:16]] <= buf_out[15:0];  // [RL15]
    end

    // page select: upper bits of the word address              [RL16]
    wire [ADDR_BITS-PAGE_BITS-1:0] page_sel =
        word_addr[ADDR_BITS-1:PAGE_BITS];

    // next state; only one operation in flight
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (live && wr_fall && is_erase)
                    nxt_state = ST_ERASE;                      // [RL14]
                else if (live && wr_fall && is_wflash && !buf_out_valid)
                    nxt_state = ST_PROG;                       // [RL17]
            end
            ST_ERASE: if (busy_cnt_ff == 16'h0000) nxt_state = ST_IDLE;
            ST_PROG:  if (busy_cnt_ff == 16'h0000) nxt_state = ST_DRAIN;
            ST_DRAIN: if (drain_idx_ff == {PAGE_BITS{1'b1}})
                          nxt_state = ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    // erase walks every word; locks drop only after the last one
    always @(posedge clk) begin
        if (rst) begin
            state_ff         <= ST_IDLE;
            busy_cnt_ff      <= 16'h0000;
            drain_idx_ff     <= {PAGE_BITS{1'b0}};
            wipe_ff          <= {(WIPE_BITS+1){1'b0}};
            lock_bits_set_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE && nxt_state == ST_ERASE) begin
                busy_cnt_ff <= ERASE_CYC[15:0];
                wipe_ff     <= {(WIPE_BITS+1){1'b0}};
            end else if (state_ff == ST_IDLE && nxt_state == ST_PROG) begin
                busy_cnt_ff  <= PROG_CYC[15:0];
                drain_idx_ff <= {PAGE_BITS{1'b0}};
            end else if (busy_cnt_ff != 16'h0000 && state_ff != ST_ERASE) begin
                busy_cnt_ff <= busy_cnt_ff - 16'h0001;
            end
            if (state_ff == ST_ERASE) begin
                if (wipe_ff < WIPE_END[WIPE_BITS:0])
                    wipe_ff <= wipe_ff + 1'b1;
                else if (busy_cnt_ff != 16'h0000)
                    busy_cnt_ff <= busy_cnt_ff - 16'h0001;
                if (nxt_state == ST_IDLE)
                    lock_bits_set_ff <= 1'b0;                  // [RL8]
            end
            if (state_ff == ST_DRAIN)
                drain_idx_ff <= drain_idx_ff + 1'b1;
        end
    end

    // array updates: erase to FF, page copy on program
    integer i;
    always @(posedge clk) begin
        if (state_ff == ST_ERASE) begin
            for (i = 0; i < WORDS; i = i + 1)
                if (wipe_ff == 0)
                    flash_mem[i] <= {`ERASED_BYTE, `ERASED_BYTE}; // [RL7][RL8]
            if (!s_fuse)                                   // [RL9]
                for (i = 0; i < EEW; i = i + 1)
                    if (wipe_ff == 0)
                        ee_mem[i] <= `ERASED_BYTE;             // [RL7]
        end else if (state_ff == ST_DRAIN) begin
            flash_mem[{page_sel, drain_idx_ff}] <=
                page_buf[drain_idx_ff];                        // [RL16]
        end
    end

    // =================================================================
    // outputs
    assign ready_flag = idle && !buf_out_valid;                // [RL20]
    assign data_oe_n  = !(prog_mode_ff && !s_oe_n);            // [RL21]

    // read back: flash word low/high by byte select
    always @(posedge clk) begin
        if (rst)
            data_out_ff <= 8'h00;
        else
            data_out_ff <= s_bs ? flash_mem[word_addr[ADDR_BITS-1:0]][15:8]
                                : flash_mem[word_addr[ADDR_BITS-1:0]][7:0];
    end

endmodule // nvm_prog_port

// ---- nvm_port_properties.sv ----
`timescale 1ns/100ps

// =====================================================================
// checker on the programming port pins
module nvm_port_properties #(
    parameter ERASE_CYC = 64,
    parameter PROG_CYC  = 16,
    parameter ADDR_BITS = 13,
    parameter EE_BITS   = 9
) (
    // clock and reset
    input wire       clk,
    input wire       rst,
    // programmer side pins
    input wire       hv_reset,
    input wire [3:0] entry_select,
    input wire       write_n,
    input wire       page_load_strobe,
    input wire       output_enable_n,
    // device outputs
    input wire       prog_mode_ff,
    input wire [7:0] data_out_ff,
    input wire       data_oe_n,
    input wire       ready_flag,
    input wire       lock_bits_set_ff
);
    // generous ceiling: wipe of flash plus eeprom plus settling
    localparam int BUSY_MAX = ERASE_CYC + PROG_CYC + 2 * (1 << ADDR_BITS)
                              + (1 << EE_BITS) + 256;
    reg [15:0] busy_cnt_ff;
    reg [7:0]  op_hist_ff;

    // busy run length and recent write or latch activity
    always @(posedge clk) begin
        busy_cnt_ff <= (rst || ready_flag) ? 16'h0000 : busy_cnt_ff + 16'h0001;
        op_hist_ff  <= {op_hist_ff[6:0], (!write_n || page_load_strobe)};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_state: assert property (
        $fell(rst) |-> ready_flag && !prog_mode_ff && lock_bits_set_ff
                       && data_oe_n && data_out_ff == 8'h00)
        else $error("state after reset is wrong");
    a_idle_bus: assert property (
        !prog_mode_ff |-> data_oe_n)
        else $error("bus driven outside programming mode");
    a_oe_gate: assert property (
        output_enable_n [*5] |-> data_oe_n)
        else $error("bus driven while output enable is high");
    a_hv_drop: assert property (
        (!hv_reset) [*5] |-> !prog_mode_ff)
        else $error("mode held without high voltage");
    a_mode_entry: assert property (
        $rose(prog_mode_ff) |-> $past(hv_reset, 2)
                                && $past(entry_select, 2) == 4'h0)
        else $error("mode entered with bad entry pins");
    a_lock_no_rise: assert property (
        !$rose(lock_bits_set_ff))
        else $error("lock bits set again without reset");
    a_lock_after_erase: assert property (
        $fell(lock_bits_set_ff) |-> !$past(ready_flag, 1)
                                    || !$past(ready_flag, 2))
        else $error("lock bits released outside an erase");
    a_busy_cause: assert property (
        $fell(ready_flag) |-> |op_hist_ff)
        else $error("busy without a write or latch strobe");
    a_busy_bound: assert property (
        busy_cnt_ff < BUSY_MAX)
        else $error("busy for too long");
    a_mode_busy: assert property (
        !ready_flag |-> prog_mode_ff)
        else $error("busy outside programming mode");
endmodule // nvm_port_properties

bind nvm_prog_port nvm_port_properties #(
    .ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC),
    .ADDR_BITS(ADDR_BITS), .EE_BITS(EE_BITS)
) u_props (
    .clk(clk), .rst(rst), .hv_reset(hv_reset), .entry_select(entry_select),
    .write_n(write_n), .page_load_strobe(page_load_strobe),
    .output_enable_n(output_enable_n), .prog_mode_ff(prog_mode_ff),
    .data_out_ff(data_out_ff), .data_oe_n(data_oe_n),
    .ready_flag(ready_flag), .lock_bits_set_ff(lock_bits_set_ff)
);

// ---- prog_bus_model.sv ----
`timescale 1ns/100ps

// =====================================================================
// shared data bus between programmer and device
module prog_bus_model (
    // clock
    input  wire       clk,
    // programmer drive
    input  wire [7:0] drv_val,
    input  wire       drv_en,
    // device drive
    input  wire [7:0] data_out_ff,
    input  wire       data_oe_n,
    // resolved bus level
    output wire [7:0] data_in
);
    reg [7:0] last_ff;

    // floating bus shows the inverse of the last level, never a stale copy
    always @(posedge clk)
        if (!data_oe_n || drv_en)
            last_ff <= data_in;
    assign data_in = !data_oe_n ? data_out_ff : drv_en ? drv_val : ~last_ff;
endmodule // prog_bus_model

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "nvm_port_defs.vh"

module tb_top;
    reg        clk = 1'b0, rst = 1'b1, hv_reset = 1'b0, load_pin = 1'b0;
    reg [3:0]  entry_select = 4'h0;
    reg        page_load_strobe = 1'b0, write_n = 1'b1, oe_n = 1'b1;
    reg        act_hi = 1'b1, act_lo = 1'b1, bsel = 1'b0, fuse = 1'b0;
    reg [7:0]  drv_val = 8'h00;
    reg        drv_en = 1'b1;
    wire [7:0] data_in, data_out_ff;
    wire       data_oe_n, ready_flag, prog_mode_ff, lock_bits_set_ff;
    integer    failures = 0, n_checks = 0, cycles = 0;
    reg [31:0] seed = 32'h3315;
    logic [10:0] exp_q[$];
    event      look;
    reg [7:0]  w_lo0, w_hi0, w_lo1, w_hi1;

    // =================================================================
    // design, bus model, clock
    nvm_prog_port #(.ADDR_BITS(10)) DUT (
        .clk(clk), .rst(rst), .hv_reset(hv_reset), .entry_select(entry_select),
        .prog_mode_ff(prog_mode_ff), .load_strobe_clock_pin(load_pin),
        .page_load_strobe(page_load_strobe), .write_n(write_n),
        .output_enable_n(oe_n), .action_select_hi(act_hi),
        .action_select_lo(act_lo), .byte_select_primary(bsel),
        .data_in(data_in), .data_out_ff(data_out_ff), .data_oe_n(data_oe_n),
        .eeprom_preserve_fuse(fuse), .ready_flag(ready_flag),
        .lock_bits_set_ff(lock_bits_set_ff));
    prog_bus_model u_bus (.clk(clk), .drv_val(drv_val), .drv_en(drv_en),
        .data_out_ff(data_out_ff), .data_oe_n(data_oe_n), .data_in(data_in));
    initial forever #20 clk = ~clk;

    // =================================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // note an expectation; sel 0 data, 1 ready, 2 mode, 3 lock, 4 bus enable
    task automatic expect_v(input logic [2:0] sel, input logic [7:0] v);
        exp_q.push_back({sel, v});
        -> look;
    endtask
    task automatic wait_ready;
        while (ready_flag !== 1'b1) tick(1);
    endtask
    // pins set, settle three cycles, pulse, hold three cycles
    task automatic load(input logic [1:0] act, input logic bs,
                        input logic [7:0] v);
        {act_hi, act_lo} = act;
        bsel = bs;
        drv_val = v;
        tick(3);
        load_pin = 1'b1;
        tick(3);
        load_pin = 1'b0;
        tick(3);
        wait_ready;
    endtask
    task automatic latch;
        bsel = 1'b1;
        tick(3);
        page_load_strobe = 1'b1;
        tick(3);
        page_load_strobe = 1'b0;
        tick(3);
        wait_ready;
    endtask
    task automatic wr;
        write_n = 1'b0;
        tick(3);
        write_n = 1'b1;
        tick(3);
        expect_v(1, 8'h00);
    endtask
    task automatic rd(input logic bs, input logic [7:0] v);
        {act_hi, act_lo} = `ACT_IDLE;
        bsel = bs;
        drv_en = 1'b0;
        oe_n = 1'b0;
        tick(6);
        expect_v(0, v);
        expect_v(4, 8'h00);
        oe_n = 1'b1;
        tick(6);
        expect_v(4, 8'h01);
        drv_en = 1'b1;
    endtask
    // six clock pin pulses, zero entry pins, then high voltage
    task automatic enter(input logic bad);
        repeat (6) begin
            load_pin = 1'b1;
            tick(2);
            load_pin = 1'b0;
            tick(2);
        end
        entry_select = `ENTRY_PATTERN;
        tick(3);
        hv_reset = 1'b1;
        if (bad) begin
            tick(1);
            entry_select = 4'h5;
        end
        tick(2);
        entry_select = `ENTRY_PATTERN;
        tick(8);
        expect_v(2, {7'h00, !bad});
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // =================================================================
    // monitor: oldest note against the output it names
    initial forever begin
        @(look);
        while (exp_q.size() > 0) begin : one
            logic [10:0] e;
            logic [7:0]  obs;
            e = exp_q.pop_front();
            case (e[10:8])
                3'h0: obs = data_out_ff;
                3'h1: obs = {7'h00, ready_flag};
                3'h2: obs = {7'h00, prog_mode_ff};
                3'h3: obs = {7'h00, lock_bits_set_ff};
                default: obs = {7'h00, data_oe_n};
            endcase
            n_checks = n_checks + 1;
            if (obs !== e[7:0]) begin
                failures = failures + 1;
                $display("wrong value at %0t: sel %0d got %h want %h",
                         $time, e[10:8], obs, e[7:0]);
            end
        end
    end

    // hang guard, the whole run needs well under this
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 12000) begin
            failures = failures + 1;
            $display("wrong value at %0t: run did not finish", $time);
            close_out;
        end
    end

    // =================================================================
    // main sequence
    initial begin
        tick(3);
        rst = 1'b0;
        tick(3);
        expect_v(1, 8'h01);
        expect_v(3, 8'h01);
        enter(1'b1);
        hv_reset = 1'b0;
        tick(6);
        enter(1'b0);
        tick(1250);
        seed = xs(seed);
        fuse = seed[0];
        // erase first, then one word reads as erased in both bytes
        load(`ACT_CMD, 1'b0, `CMD_CHIP_ERASE);
        wr();
        wait_ready;
        expect_v(3, 8'h00);
        load(`ACT_ADDR, 1'b1, 8'h03);
        load(`ACT_ADDR, 1'b0, 8'h2A);
        rd(1'b0, `ERASED_BYTE);
        rd(1'b1, `ERASED_BYTE);
        seed = xs(seed);
        {w_hi0, w_lo0, w_hi1, w_lo1} = seed;
        // two pages under one command and one high byte
        load(`ACT_CMD, 1'b0, `CMD_WRITE_FLASH);
        load(`ACT_ADDR, 1'b0, 8'h05);
        load(`ACT_DATA, 1'b0, w_lo0);
        load(`ACT_DATA, 1'b1, w_hi0);
        latch();
        load(`ACT_ADDR, 1'b1, 8'h02);
        wr();
        wait_ready;
        load(`ACT_ADDR, 1'b0, 8'h45);
        load(`ACT_DATA, 1'b0, w_lo1);
        load(`ACT_DATA, 1'b1, w_hi1);
        latch();
        wr();
        load(`ACT_ADDR, 1'b0, 8'h05);
        rd(1'b0, w_lo1);
        rd(1'b1, w_hi1);
        load(`ACT_ADDR, 1'b0, 8'h05);
        load(`ACT_IDLE, 1'b0, 8'h45);
        rd(1'b0, w_lo0);
        rd(1'b1, w_hi0);
        hv_reset = 1'b0;
        tick(8);
        expect_v(2, 8'h00);
        tick(2);
        close_out;
    end
endmodule // tb_top
